// >>> core/gcb_desc_check.sv
// descriptor flag qualifier driven by the capability fields
`timescale 1ns/1ps
`default_nettype none
module gcb_desc_check (
  input  wire gcb_pkg::gcb_cap_type     cap,
  input  wire logic                     pasid_en,
  input  wire gcb_pkg::gcb_desc_type    desc,
  output var  gcb_pkg::gcb_verdict_type verdict
);

  logic crc_op;
  logic fill_op;
  logic flag_bad;
  logic id_bad;
  logic size_bad;

  always_comb
  begin
    crc_op  = (desc.op == gcb_pkg::GCB_OP_CRC_GEN) || (desc.op == gcb_pkg::GCB_OP_COPY_CRC);
    fill_op = (desc.op == gcb_pkg::GCB_OP_FILL) || (desc.op == gcb_pkg::GCB_OP_ID_FILL);
    // queue limits sit at or below this, so the device cap is the last line of defence
    size_bad = {1'b0, desc.xfer_size} > gcb_pkg::gcb_xfer_limit(cap.xfer_log2);
    flag_bad = (crc_op && desc.crc_size && !cap.crc64)
            || (fill_op && desc.pattern_size && !cap.wide_pattern_fill_support)
            || ((desc.op == gcb_pkg::GCB_OP_DRAIN) && (desc.rb_valid != 2'h0)
                && !cap.drain_rb)
            || (desc.hint_dest_rb && !cap.dest_rb)
            || (desc.hint_durable && !cap.durable)
            || (desc.batch_error && !cap.batch_cont);
    id_bad = (desc.op == gcb_pkg::GCB_OP_ID_FILL) && !(cap.interdomain && pasid_en);

    verdict               = '0;
    verdict.size_err      = size_bad;
    verdict.flag_err      = flag_bad;
    verdict.id_err        = id_bad;
    verdict.accept        = !(size_bad || flag_bad || id_bad);
    verdict.crc64_on      = crc_op && desc.crc_size && cap.crc64;
    verdict.wide_pattern_fill_support_on     = fill_op && desc.pattern_size && cap.wide_pattern_fill_support;
    verdict.rb_issue      = ((desc.op == gcb_pkg::GCB_OP_DRAIN) && cap.drain_rb)
                            ? desc.rb_valid : 2'h0;
    verdict.dest_rb_on    = desc.hint_dest_rb && cap.dest_rb;
    verdict.durable_on    = desc.hint_durable && cap.durable;
    // stride flag is simply dropped when unsupported, never an error
    verdict.stride_on     = (desc.op == gcb_pkg::GCB_OP_XLAT) && cap.stride
                            && desc.use_stride;
    verdict.batch_err_on  = desc.batch_error && cap.batch_cont;
    verdict.fault_info_on = cap.fault_info;
    verdict.evlog_bytes   = gcb_pkg::gcb_evlog_bytes(cap.evlog);
  end

endmodule
`default_nettype wire

// >>> core/gcb_general_capability.sv
// general capability register with descriptor qualification and assertions
`timescale 1ns/1ps
`default_nettype none
module gcb_general_capability #(
  parameter logic [4:0] CAP_XFER_LOG2   = 5'h15,
  parameter logic       CAP_BATCH_CONT  = 1'b1,
  parameter logic [1:0] CAP_EVLOG       = 2'h1,
  parameter logic       CAP_FAULT_INFO  = 1'b1,
  parameter logic       CAP_CRC64       = 1'b1,
  parameter logic       CAP_WIDE_PATTERN_FILL_SUPPORT      = 1'b1,
  parameter logic       CAP_DRAIN_RB    = 1'b1,
  parameter logic       CAP_DEST_RB     = 1'b0,
  parameter logic       CAP_STRIDE      = 1'b1,
  parameter logic       CAP_INTERDOMAIN = 1'b1,
  parameter logic       CAP_DURABLE     = 1'b0
) (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  input  wire logic                     reg_rd_req,
  input  wire logic                     reg_wr_req,
  input  wire logic [11:0]              reg_addr,
  input  wire logic [63:0]              reg_wr_data,
  output var  logic [63:0]              reg_rd_data,
  output var  logic                     reg_rd_ack,
  output var  logic                     reg_wr_ack,
  input  wire logic                     pasid_enable,
  input  wire logic                     desc_valid,
  input  wire gcb_pkg::gcb_desc_type    desc,
  output var  logic                     verdict_valid,
  output var  gcb_pkg::gcb_verdict_type verdict
);

  // fixed at build time; nothing in the design can alter it
  localparam gcb_pkg::gcb_cap_type CAP = '{
    xfer_log2:                 CAP_XFER_LOG2,
    batch_cont:                CAP_BATCH_CONT,
    evlog:                     CAP_EVLOG,
    fault_info:                CAP_FAULT_INFO,
    crc64:                     CAP_CRC64,
    wide_pattern_fill_support: CAP_WIDE_PATTERN_FILL_SUPPORT,
    drain_rb:                  CAP_DRAIN_RB,
    dest_rb:                   CAP_DEST_RB,
    stride:                    CAP_STRIDE,
    interdomain:               CAP_INTERDOMAIN,
    durable:                   CAP_DURABLE
  };

  localparam logic [63:0] CAP_WORD = gcb_pkg::gcb_place(CAP);

  // register read and write port
  logic [63:0] rd_data_reg;
  logic [63:0] rd_data_next;
  logic        rd_ack_reg;
  logic        rd_ack_next;
  logic        wr_ack_reg;
  logic        wr_ack_next;
  logic        addr_hit;

  // pasid enable synchroniser
  logic        pasid_meta_reg;
  logic        pasid_s2_reg;
  logic        pasid_s3_reg;
  logic        pasid_ok_reg;
  logic        pasid_ok_next;

  // descriptor verdict
  gcb_pkg::gcb_verdict_type check_out;
  gcb_pkg::gcb_verdict_type verdict_reg;
  gcb_pkg::gcb_verdict_type verdict_next;
  logic                     verdict_valid_reg;
  logic                     verdict_valid_next;

  assign addr_hit = (reg_addr == gcb_pkg::GCB_CAP_OFFSET);

  always_comb
  begin
    rd_data_next = rd_data_reg;
    rd_ack_next  = 1'b0;
    wr_ack_next  = 1'b0;
    if (reg_rd_req)
    begin
      rd_ack_next  = 1'b1;
      // whole 64-bit word in one read, so no tearing between halves
      rd_data_next = addr_hit ? CAP_WORD : gcb_pkg::GCB_UNMAPPED_DATA;
    end
    if (reg_wr_req)
    begin
      // write acknowledged but data discarded; the field stays put
      wr_ack_next = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rd_data_reg <= gcb_pkg::GCB_RD_RESET;
      rd_ack_reg  <= 1'b0;
      wr_ack_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_data_reg <= rd_data_next;
      rd_ack_reg  <= rd_ack_next;
      wr_ack_reg  <= wr_ack_next;
    end
  end

  // pasid state comes from another block's domain; accept only settled values
  always_comb
  begin
    pasid_ok_next = (pasid_s2_reg == pasid_s3_reg) ? pasid_s3_reg : pasid_ok_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pasid_meta_reg <= 1'b0;
      pasid_s2_reg   <= 1'b0;
      pasid_s3_reg   <= 1'b0;
      pasid_ok_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      pasid_meta_reg <= pasid_enable;
      pasid_s2_reg   <= pasid_meta_reg;
      pasid_s3_reg   <= pasid_s2_reg;
      pasid_ok_reg   <= pasid_ok_next;
    end
  end

  gcb_desc_check u_check (
    .cap      (CAP),
    .pasid_en (pasid_ok_reg),
    .desc     (desc),
    .verdict  (check_out)
  );

  always_comb
  begin
    verdict_valid_next = desc_valid;
    verdict_next       = desc_valid ? check_out : verdict_reg;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      verdict_valid_reg <= 1'b0;
      verdict_reg       <= '0;
    end
    else if (clk_en)
    begin
      verdict_valid_reg <= verdict_valid_next;
      verdict_reg       <= verdict_next;
    end
  end

  assign reg_rd_data   = rd_data_reg;
  assign reg_rd_ack    = rd_ack_reg;
  assign reg_wr_ack    = wr_ack_reg;
  assign verdict_valid = verdict_valid_reg;
  assign verdict       = verdict_reg;

  // register port checks

  a_cap_read_value: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && reg_rd_req && addr_hit |=> reg_rd_ack && (reg_rd_data == CAP_WORD))
    else $error("capability read did not return the fixed word");

  a_unmapped_read_zero: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && reg_rd_req && !addr_hit |=> reg_rd_ack && (reg_rd_data == 64'h0))
    else $error("unmapped read returned nonzero data");

  a_xfer_field_value: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && reg_rd_req && addr_hit
    |=> reg_rd_data[gcb_pkg::GCB_XFER_MSB:gcb_pkg::GCB_XFER_LSB] == CAP_XFER_LOG2)
    else $error("transfer size field differs from its parameter");

  a_write_ignored_data: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && reg_wr_req && !reg_rd_req
    |=> reg_wr_ack && (reg_rd_data == $past(reg_rd_data)))
    else $error("write disturbed the read data");

  a_write_then_read: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && reg_wr_req ##1 clk_en && reg_rd_req && addr_hit
    |=> reg_rd_data == CAP_WORD)
    else $error("capability changed after a write");

  a_rd_ack_pulse: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && !reg_rd_req |=> !reg_rd_ack)
    else $error("read acknowledge without a read");

  a_wr_ack_pulse: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && !reg_wr_req |=> !reg_wr_ack)
    else $error("write acknowledge without a write");

  a_freeze_holds: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !clk_en |=> $stable(reg_rd_data) && $stable(reg_rd_ack) && $stable(verdict_valid))
    else $error("state moved while the clock enable was low");

  // descriptor gating checks

  a_size_limit_err: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && ({1'b0, desc.xfer_size} > (33'h1 << CAP_XFER_LOG2))
    |=> verdict_valid && verdict.size_err && !verdict.accept)
    else $error("oversize transfer was accepted");

  a_batch_cont_gate: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && desc.batch_error
    |=> (verdict.batch_err_on == CAP_BATCH_CONT) && (verdict.flag_err || CAP_BATCH_CONT))
    else $error("batch error flag gating wrong");

  a_evlog_size_map: assert property (
    @(posedge mclk) disable iff (sys_rst)
    verdict_valid |-> verdict.evlog_bytes == gcb_pkg::gcb_evlog_bytes(CAP_EVLOG))
    else $error("event log entry size mismatch");

  a_fault_info_flag: assert property (
    @(posedge mclk) disable iff (sys_rst)
    verdict_valid |-> verdict.fault_info_on == CAP_FAULT_INFO)
    else $error("fault info presence mismatch");

  a_crc64_gate: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && desc.crc_size
    && (desc.op == gcb_pkg::GCB_OP_CRC_GEN || desc.op == gcb_pkg::GCB_OP_COPY_CRC)
    |=> (verdict.crc64_on == CAP_CRC64) && (CAP_CRC64 || verdict.flag_err))
    else $error("crc size flag gating wrong");

  a_wide_pattern_fill_support_gate: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && desc.pattern_size
    && (desc.op == gcb_pkg::GCB_OP_FILL || desc.op == gcb_pkg::GCB_OP_ID_FILL)
    |=> verdict.wide_pattern_fill_support_on == CAP_WIDE_PATTERN_FILL_SUPPORT)
    else $error("pattern size flag gating wrong");

  a_drain_readback: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && (desc.op == gcb_pkg::GCB_OP_DRAIN)
    |=> verdict.rb_issue == (CAP_DRAIN_RB ? $past(desc.rb_valid) : 2'h0))
    else $error("drain readback issue mismatch");

  a_dest_rb_hint: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && desc.hint_dest_rb
    |=> (verdict.dest_rb_on == CAP_DEST_RB) && (CAP_DEST_RB || !verdict.accept))
    else $error("destination readback hint gating wrong");

  a_stride_ignored: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && (desc.op == gcb_pkg::GCB_OP_XLAT) && desc.use_stride
    |=> verdict.stride_on == CAP_STRIDE)
    else $error("use stride flag gating wrong");

  a_interdomain_block: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && (desc.op == gcb_pkg::GCB_OP_ID_FILL)
    && !(CAP_INTERDOMAIN && pasid_ok_reg)
    |=> verdict.id_err && !verdict.accept)
    else $error("cross-domain operation accepted without support");

  a_durable_hint: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && desc.hint_durable
    |=> (verdict.durable_on == CAP_DURABLE) && (CAP_DURABLE || verdict.flag_err))
    else $error("durable write hint gating wrong");

  a_size_within_limit: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && ({1'b0, desc.xfer_size} <= (33'h1 << CAP_XFER_LOG2))
    |=> verdict_valid && !verdict.size_err)
    else $error("transfer within the advertised limit was refused");

  a_wide_pattern_fill_support_reject: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && desc.pattern_size
    && (desc.op == gcb_pkg::GCB_OP_FILL || desc.op == gcb_pkg::GCB_OP_ID_FILL)
    |=> CAP_WIDE_PATTERN_FILL_SUPPORT || (verdict.flag_err && !verdict.accept))
    else $error("unsupported pattern size flag was accepted");

  a_drain_reserved: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && (desc.op == gcb_pkg::GCB_OP_DRAIN) && (desc.rb_valid != 2'h0)
    |=> CAP_DRAIN_RB || (verdict.flag_err && !verdict.accept))
    else $error("readback fields used without drain readback support");

  a_interdomain_allow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && desc_valid && (desc.op == gcb_pkg::GCB_OP_ID_FILL) && CAP_INTERDOMAIN
    && pasid_ok_reg |=> !verdict.id_err)
    else $error("cross-domain operation refused with support and pasid on");

  a_pasid_settle: assert property (
    @(posedge mclk) disable iff (sys_rst)
    clk_en && (pasid_s2_reg == pasid_s3_reg) |=> pasid_ok_reg == $past(pasid_s3_reg))
    else $error("pasid enable not taken once settled");

endmodule
`default_nettype wire

// >>> core/gcb_pkg.sv
// package: general capability register layout, fields and descriptor carriers
// Function
// - bits 20:16 report N; largest descriptor transfer is two to the N
// - bit 15 set exactly when batch error flag and batch result are supported
// - bits 14:13 give event log: none, 64, 128 or 256 byte entries
// - bit 12 one means completion records carry fault info, zero means none
// - crc size flag honoured in crc descriptors only when bit 11 is one
// - pattern size flag honoured in fill descriptors only when bit 10 is one
// - bit 9 zero makes drain readback fields reserved; one issues each valid readback
// - destination readback hints supported only when bit 8 is one
// - bit 7 zero ignores use-stride and uses own stride; one honours it
// - bit 6 one allows cross-domain operations only while pasid is enabled
// - durable write hints supported when bit 5 is one, otherwise unsupported
// - register is 64-bit read-only at offset 0x10 of first region
package gcb_pkg;

  localparam logic [11:0] GCB_CAP_OFFSET    = 12'h010;
  localparam int          GCB_FIELD_LSB     = 5;
  localparam int          GCB_FIELD_MSB     = 20;
  localparam int          GCB_XFER_LSB      = 16;
  localparam int          GCB_XFER_MSB      = 20;
  localparam logic [63:0] GCB_UNMAPPED_DATA = 64'h0;
  localparam logic [63:0] GCB_RD_RESET      = 64'h0;
  localparam int          GCB_RD_LATENCY    = 1;

  localparam logic [1:0] GCB_EVLOG_NONE = 2'h0;
  localparam logic [1:0] GCB_EVLOG_64   = 2'h1;
  localparam logic [1:0] GCB_EVLOG_128  = 2'h2;
  localparam logic [1:0] GCB_EVLOG_256  = 2'h3;

  // field order matches bits 20 down to 5 of the register
  typedef struct packed {
    logic [4:0] xfer_log2;
    logic       batch_cont;
    logic [1:0] evlog;
    logic       fault_info;
    logic       crc64;
    logic       wide_pattern_fill_support;
    logic       drain_rb;
    logic       dest_rb;
    logic       stride;
    logic       interdomain;
    logic       durable;
  } gcb_cap_type;

  typedef enum logic [2:0] {
    GCB_OP_COPY     = 3'h0,
    GCB_OP_CRC_GEN  = 3'h1,
    GCB_OP_COPY_CRC = 3'h2,
    GCB_OP_FILL     = 3'h3,
    GCB_OP_ID_FILL  = 3'h4,
    GCB_OP_DRAIN    = 3'h5,
    GCB_OP_XLAT     = 3'h6,
    GCB_OP_BATCH    = 3'h7
  } gcb_op_type;

  typedef struct packed {
    gcb_op_type  op;
    logic        crc_size;
    logic        pattern_size;
    logic [1:0]  rb_valid;
    logic        hint_dest_rb;
    logic        hint_durable;
    logic        use_stride;
    logic        batch_error;
    logic [31:0] xfer_size;
  } gcb_desc_type;

  typedef struct packed {
    logic       accept;
    logic       size_err;
    logic       flag_err;
    logic       id_err;
    logic       crc64_on;
    logic       wide_pattern_fill_support_on;
    logic [1:0] rb_issue;
    logic       dest_rb_on;
    logic       durable_on;
    logic       stride_on;
    logic       batch_err_on;
    logic       fault_info_on;
    logic [8:0] evlog_bytes;
  } gcb_verdict_type;

  function automatic logic [8:0] gcb_evlog_bytes(input logic [1:0] code);
    logic [8:0] b;
    b = 9'h000;
    unique case (code)
      GCB_EVLOG_NONE: b = 9'h000;
      GCB_EVLOG_64:   b = 9'h040;
      GCB_EVLOG_128:  b = 9'h080;
      GCB_EVLOG_256:  b = 9'h100;
    endcase
    return b;
  endfunction

  function automatic logic [32:0] gcb_xfer_limit(input logic [4:0] n);
    return 33'h1 << n;
  endfunction

  function automatic logic [63:0] gcb_place(input gcb_cap_type cap);
    logic [63:0] w;
    w = 64'h0;
    w[GCB_FIELD_MSB:GCB_FIELD_LSB] = cap;
    return w;
  endfunction

endpackage

// >>> verif/tb.sv
// self-checking bench for the general capability register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
      mismatches++; \
    end \
  end
module tb;
  // four capability sets so every field value is seen set and clear
  localparam gcb_pkg::gcb_cap_type CAPS [4] = '{
    '{5'h15, 1'b1, 2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
    '{5'h0C, 1'b0, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
    '{5'h00, 1'b1, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
    '{5'h1F, 1'b0, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}};
  logic                         mclk = 1'b0;
  logic                         sys_rst = 1'b1;
  logic                         clk_en = 1'b1;
  logic                         reg_rd_req = 1'b0;
  logic                         reg_wr_req = 1'b0;
  logic [11:0]                  reg_addr = 12'h000;
  logic [63:0]                  reg_wr_data = 64'h0;
  logic                         pasid_enable = 1'b0;
  logic                         desc_valid = 1'b0;
  gcb_pkg::gcb_desc_type        desc = '0;
  gcb_pkg::gcb_desc_type        dprev;
  logic [63:0]                  rd_data [4];
  logic                         rd_ack [4];
  logic                         wr_ack [4];
  logic                         vv [4];
  gcb_pkg::gcb_verdict_type     vd [4];
  logic [31:0]                  seed = 32'h23C4625E;
  int                           mismatches = 0;
  int                           checks_done = 0;

  always #2.5 mclk = ~mclk;

  for (genvar g = 0; g < 4; g++)
  begin : g_dut
    gcb_general_capability #(
      .CAP_XFER_LOG2   (CAPS[g].xfer_log2),
      .CAP_BATCH_CONT  (CAPS[g].batch_cont),
      .CAP_EVLOG       (CAPS[g].evlog),
      .CAP_FAULT_INFO  (CAPS[g].fault_info),
      .CAP_CRC64       (CAPS[g].crc64),
      .CAP_WIDE_PATTERN_FILL_SUPPORT      (CAPS[g].wide_pattern_fill_support),
      .CAP_DRAIN_RB    (CAPS[g].drain_rb),
      .CAP_DEST_RB     (CAPS[g].dest_rb),
      .CAP_STRIDE      (CAPS[g].stride),
      .CAP_INTERDOMAIN (CAPS[g].interdomain),
      .CAP_DURABLE     (CAPS[g].durable)
    ) gcb_general_capability_inst (
      .mclk          (mclk),
      .sys_rst       (sys_rst),
      .clk_en        (clk_en),
      .reg_rd_req    (reg_rd_req),
      .reg_wr_req    (reg_wr_req),
      .reg_addr      (reg_addr),
      .reg_wr_data   (reg_wr_data),
      .reg_rd_data   (rd_data[g]),
      .reg_rd_ack    (rd_ack[g]),
      .reg_wr_ack    (wr_ack[g]),
      .pasid_enable  (pasid_enable),
      .desc_valid    (desc_valid),
      .desc          (desc),
      .verdict_valid (vv[g]),
      .verdict       (vd[g])
    );
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h80200003 : 32'h0);
  endfunction

  function automatic logic [63:0] word_of(input gcb_pkg::gcb_cap_type c);
    logic [63:0] w;
    w = 64'h0;
    w[20:16] = c.xfer_log2;
    w[15] = c.batch_cont;
    w[14:13] = c.evlog;
    w[12] = c.fault_info;
    w[11] = c.crc64;
    w[10] = c.wide_pattern_fill_support;
    w[9] = c.drain_rb;
    w[8] = c.dest_rb;
    w[7] = c.stride;
    w[6] = c.interdomain;
    w[5] = c.durable;
    return w;
  endfunction

  task automatic close_out;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one read, optionally with a write in the same cycle
  task automatic rd(input logic [11:0] a, input logic wr);
    @(negedge mclk);
    reg_addr = a;
    reg_rd_req = 1'b1;
    reg_wr_req = wr;
    seed = lfsr(seed);
    reg_wr_data = {seed, ~seed};
    @(negedge mclk);
    reg_rd_req = 1'b0;
    reg_wr_req = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      `CHK("rd_ack", 1'b1, rd_ack[k])
      `CHK("wr_ack", wr, wr_ack[k])
      `CHK("rd_data", (a == 12'h010) ? word_of(CAPS[k]) : 64'h0, rd_data[k])
    end
  endtask

  // write alone, then a read in the very next cycle
  task automatic wr_rd(input logic [11:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_wr_req = 1'b1;
    seed = lfsr(seed);
    reg_wr_data = {~seed, seed};
    @(negedge mclk);
    reg_wr_req = 1'b0;
    reg_rd_req = 1'b1;
    reg_addr = 12'h010;
    for (int k = 0; k < 4; k++)
    begin
      `CHK("wo_wr_ack", 1'b1, wr_ack[k])
      `CHK("wo_rd_ack", 1'b0, rd_ack[k])
      `CHK("wo_rd_data", word_of(CAPS[k]), rd_data[k])
    end
    @(negedge mclk);
    reg_rd_req = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      `CHK("wr_rd_ack", 1'b1, rd_ack[k])
      `CHK("wr_rd_data", word_of(CAPS[k]), rd_data[k])
    end
  endtask

  task automatic chk_vd(input int k, input gcb_pkg::gcb_desc_type d, input logic pas);
    gcb_pkg::gcb_cap_type     c;
    gcb_pkg::gcb_verdict_type v;
    logic                     se;
    logic                     fe;
    logic                     ie;
    logic                     ok;
    logic [5:0]               on_ex;
    logic [5:0]               on_seen;
    c = CAPS[k];
    v = vd[k];
    se = {1'b0, d.xfer_size} > (33'h1 << c.xfer_log2);
    fe = (d.op inside {gcb_pkg::GCB_OP_CRC_GEN, gcb_pkg::GCB_OP_COPY_CRC}) & d.crc_size & !c.crc64;
    fe |= (d.op inside {gcb_pkg::GCB_OP_FILL, gcb_pkg::GCB_OP_ID_FILL}) & d.pattern_size
          & !c.wide_pattern_fill_support;
    fe |= (d.op == gcb_pkg::GCB_OP_DRAIN) & (|d.rb_valid) & !c.drain_rb;
    fe |= (d.hint_dest_rb & !c.dest_rb) | (d.hint_durable & !c.durable);
    fe |= d.batch_error & !c.batch_cont;
    ie = (d.op == gcb_pkg::GCB_OP_ID_FILL) & !(c.interdomain & pas);
    ok = !(se | fe | ie);
    `CHK("verdict_valid", 1'b1, vv[k])
    `CHK("size_err", se, v.size_err)
    `CHK("flag_err", fe, v.flag_err)
    `CHK("id_err", ie, v.id_err)
    `CHK("accept", ok, v.accept)
    `CHK("fault_info_on", c.fault_info, v.fault_info_on)
    `CHK("evlog_bytes", (c.evlog == 2'h0) ? 9'h000 : 9'h020 << c.evlog, v.evlog_bytes)
    on_ex = {(d.op inside {gcb_pkg::GCB_OP_CRC_GEN, gcb_pkg::GCB_OP_COPY_CRC})
             & d.crc_size & c.crc64,
             (d.op inside {gcb_pkg::GCB_OP_FILL, gcb_pkg::GCB_OP_ID_FILL})
             & d.pattern_size & c.wide_pattern_fill_support,
             d.hint_dest_rb & c.dest_rb,
             d.hint_durable & c.durable,
             (d.op == gcb_pkg::GCB_OP_XLAT) & d.use_stride & c.stride,
             d.batch_error & c.batch_cont};
    on_seen = {v.crc64_on, v.wide_pattern_fill_support_on, v.dest_rb_on, v.durable_on, v.stride_on, v.batch_err_on};
    `CHK("on_flags", on_ex, on_seen)
    if (ok && d.op == gcb_pkg::GCB_OP_DRAIN && c.drain_rb)
      `CHK("rb_issue", d.rb_valid, v.rb_issue)
    if (ok && d.op == gcb_pkg::GCB_OP_XLAT && c.stride)
      `CHK("stride_on", d.use_stride, v.stride_on)
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    close_out();
  end

  initial
  begin
    logic [31:0] r2;
    repeat (8) @(negedge mclk);
    sys_rst = 1'b0;
    for (int k = 0; k < 4; k++)
      `CHK("rst_rd_data", 64'h0, rd_data[k])
    rd(12'h010, 1'b0);
    rd(12'h014, 1'b0);
    rd(12'h010, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      rd((seed[11:0] == 12'h010) ? 12'h018 : seed[11:0], seed[12]);
      rd(12'h010, 1'b0);
      wr_rd(seed[23:12]);
    end
    // frozen clock enable must not take the pending read
    @(negedge mclk);
    clk_en = 1'b0;
    reg_rd_req = 1'b1;
    repeat (3) @(negedge mclk);
    for (int k = 0; k < 4; k++)
      `CHK("frozen_ack", 1'b0, rd_ack[k])
    clk_en = 1'b1;
    @(negedge mclk);
    reg_rd_req = 1'b0;
    for (int k = 0; k < 4; k++)
      `CHK("thawed_ack", 1'b1, rd_ack[k])
    for (int p = 0; p < 2; p++)
    begin
      pasid_enable = p[0];
      repeat (6) @(negedge mclk);
      for (int i = 0; i <= 60; i++)
      begin
        @(negedge mclk);
        if (i > 0)
          for (int k = 0; k < 4; k++)
            chk_vd(k, dprev, p[0]);
        seed = lfsr(seed);
        r2 = seed;
        seed = lfsr(seed);
        desc = gcb_pkg::gcb_desc_type'({r2[10:0], 32'h0});
        // sizes straddle the limits of the first three sets, the fourth set's limit only meets random sizes; queue limit never set above it
        case (r2[15:13])
          3'h0: desc.xfer_size = 32'h00200000;
          3'h1: desc.xfer_size = 32'h00200001;
          3'h2: desc.xfer_size = 32'h00001000;
          3'h3: desc.xfer_size = 32'h00001001;
          3'h4: desc.xfer_size = {31'h0, r2[16]} + 32'h1;
          default: desc.xfer_size = seed;
        endcase
        desc_valid = (i < 60);
        dprev = desc;
      end
      @(negedge mclk);
      for (int k = 0; k < 4; k++)
        `CHK("verdict_idle", 1'b0, vv[k])
    end
    // reset in mid-run leaves the capability word unchanged afterwards
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    for (int k = 0; k < 4; k++)
      `CHK("mid_rst_data", 64'h0, rd_data[k])
    sys_rst = 1'b0;
    rd(12'h010, 1'b1);
    close_out();
  end
endmodule
`default_nettype wire
